//--- design/tsb_pkg.sv
package tsb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TSB_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TSB_STATUS_OFS = 8'h04;
  localparam logic [7:0] TSB_CFGA_OFS   = 8'h08;
  localparam logic [7:0] TSB_CFGB_OFS   = 8'h0c;
  localparam logic [7:0] TSB_CARR_OFS   = 8'h10;
  localparam logic [7:0] TSB_DEV_OFS    = 8'h14;
  localparam logic [7:0] TSB_FRX_OFS    = 8'h18;
  localparam logic [7:0] TSB_FTXL_OFS   = 8'h1c;
  localparam logic [7:0] TSB_FTXH_OFS   = 8'h20;
  localparam logic [7:0] TSB_CMD_OFS    = 8'h24;

  // ----------------------------------------------------------------
  // Control and command register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT    = 0;
  localparam int CTRL_BAND_LO_BIT = 1;
  localparam int CTRL_BAND_HI_BIT = 2;
  localparam int CTRL_LOF_LO_BIT  = 3;
  localparam int CTRL_LOF_HI_BIT  = 4;
  localparam int CTRL_DME_BIT     = 5;
  localparam int CTRL_FSK_BIT     = 6;
  localparam int CTRL_DIRECT_BIT  = 7;
  localparam int CTRL_MODE_LSB    = 8;
  localparam int CTRL_RXGAIN_LSB  = 10;
  localparam int CTRL_TXPWR_LSB   = 12;
  localparam int CTRL_AUTOSW_BIT  = 14;
  localparam int CMD_CFGSW_BIT    = 0;

  // Status register fields
  localparam int STAT_LVDS_BIT    = 0;
  localparam int STAT_LOCK_BIT    = 1;
  localparam int STAT_TXSTOP_BIT  = 2;
  localparam int STAT_SWITCH_BIT  = 3;
  localparam int STAT_STATE_LSB   = 4;
  localparam int STAT_CFGSEL_BIT  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] FREQ_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Band codes, dividers, mode requests
  // ----------------------------------------------------------------
  localparam logic [1:0] BAND_300 = 2'h0;
  localparam logic [1:0] BAND_430 = 2'h1;
  localparam logic [1:0] BAND_900 = 2'h3;
  localparam logic [7:0] DATACLK_DIV_LOW  = 8'd60;
  localparam logic [7:0] DATACLK_DIV_HIGH = 8'd80;
  localparam logic [7:0] DIGCLK_DIV_LOW   = 8'd30;
  localparam logic [7:0] DIGCLK_DIV_HIGH  = 8'd40;
  localparam logic [7:0] IF_DIV_LOW       = 8'd9;
  localparam logic [7:0] IF_DIV_HIGH      = 8'd12;
  localparam logic [1:0] REQ_STANDBY = 2'h0;
  localparam logic [1:0] REQ_RX      = 2'h1;
  localparam logic [1:0] REQ_TX      = 2'h2;
  localparam logic [7:0] HALF_BIT_CYCLES = 8'd16;

  typedef enum logic [2:0] {
    TSB_STANDBY,
    TSB_LVD,
    TSB_RX,
    TSB_TX
  } tsb_mode_e;

endpackage

//--- design/tsb_clk_div.sv
`timescale 1ns/1ps
module tsb_clk_div
  import tsb_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] div,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tsb_div_s;

  tsb_div_s st_r;
  tsb_div_s st_nxt;

  // Count to div-1, then emit one pulse; a new divisor applies at once to the count in progress
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= div - W'(1)) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

//--- design/tsb_manchester.sv
`timescale 1ns/1ps
module tsb_manchester
  import tsb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic din,
  output logic      bit_out,
  output logic      bit_stb
);

  typedef struct packed {
    logic       din_d;
    logic [7:0] cnt;
    logic       phase;
    logic       bit_out;
    logic       bit_stb;
  } tsb_man_s;

  tsb_man_s st_r;
  tsb_man_s st_nxt;

  // Edge spacing tells mid-bit edges from bit-boundary edges; a long
  // gap can only be a mid-bit edge, so it also resynchronises phase
  always_comb begin
    st_nxt         = st_r;
    st_nxt.bit_stb = 1'b0;
    st_nxt.din_d   = din;
    if (st_r.cnt != 8'hff) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    if (!enable) begin
      st_nxt.phase = 1'b0;
      st_nxt.cnt   = 8'h00;
    end else if (din != st_r.din_d) begin
      st_nxt.cnt = 8'h00;
      if (st_r.cnt > HALF_BIT_CYCLES + (HALF_BIT_CYCLES >> 1)) begin
        st_nxt.bit_out = din;
        st_nxt.bit_stb = 1'b1;
        st_nxt.phase   = 1'b0;
      end else if (st_r.phase) begin
        st_nxt.bit_out = din;
        st_nxt.bit_stb = 1'b1;
        st_nxt.phase   = 1'b0;
      end else begin
        st_nxt.phase = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_out = st_r.bit_out;
  assign bit_stb = st_r.bit_stb;

endmodule

//--- design/tsb_core.sv
// Operation
// - Power-on reset returns every configuration and status register.
// - With detection enabled, low supply sets the low-voltage flag.
// - Low-voltage flag stays latched; a host read clears it.
// - Standby request with detection enabled enters low-voltage mode.
// - Data manager on: recover clock, decode Manchester, output both.
// - Data manager off: sliced receive data goes straight out.
// - Two receiver configurations; swap on wakeup or host command.
// - Out-of-lock synthesizer: received data is discarded.
// - Transmit mode: losing lock stops transmission.
// - Switch output toggles on every receive/transmit direction change.
// - Host sends coded data; amplitude keys carrier, frequency shifts it.
// - Band bits: 00 low bands, 01 mid bands, 11 high bands.
// - Data clock divides 60/30 for band 00, else 80/40.
// - IF reference divides crystal by 9 or 12 per low band bit.
// - Four receive gain reduction steps are programmable.
// - Four transmit power reduction steps are programmable.
// - Frequency words computed from carrier/deviation, or written directly.
// - Oscillator multiplier is two in the high band, four otherwise.
// - Mode controller advances on the divided digital clock.
// - After reset the controller is in standby with reset values.
`timescale 1ns/1ps
module tsb_core
  import tsb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_low,
  input  wire logic        pll_locked,
  input  wire logic        sliced_rx_data,
  input  wire logic        tx_coded_data,
  input  wire logic        wakeup,
  output logic             rf_switch,
  output logic             pa_enable,
  output logic             tx_ook_key,
  output logic      [15:0] synth_word,
  output logic      [1:0]  lna_gain_step,
  output logic      [1:0]  pa_power_step,
  output logic             rx_data,
  output logic             rx_clk,
  output logic      [15:0] rx_cfg,
  output logic             dataclk_tick,
  output logic             digclk_tick,
  output logic             ifref_tick,
  output logic             lo_mult_four,
  output logic             lvd_monitor_on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] carrier;
    logic [15:0] dev;
    logic [15:0] f_rx;
    logic [15:0] f_txl;
    logic [15:0] f_txh;
    logic        lvds;
    logic        tx_stop;
    logic        sw;
    logic        cfg_sel;
    tsb_mode_e   mode;
    logic [31:0] prdata;
    logic        rx_data;
    logic        rx_clk;
    logic [15:0] rx_cfg;
    logic [15:0] synth;
    logic        pa_en;
    logic        ook;
  } tsb_core_s;

  tsb_core_s st_r;
  tsb_core_s st_nxt;

  logic [1:0]  band;
  logic [7:0]  data_div;
  logic [7:0]  dig_div;
  logic [7:0]  if_div;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        stat_rd;
  logic        dme;
  logic        fsk;
  logic        man_bit;
  logic        man_stb;
  logic [1:0]  mode_req;
  logic        lvd_set;
  tsb_mode_e   mode_tgt;

  assign band     = {st_r.ctrl[CTRL_BAND_HI_BIT], st_r.ctrl[CTRL_BAND_LO_BIT]};
  assign dme      = st_r.ctrl[CTRL_DME_BIT];
  assign fsk      = st_r.ctrl[CTRL_FSK_BIT];
  assign mode_req = st_r.ctrl[CTRL_MODE_LSB +: 2];

  // ----------------------------------------------------------------
  // Clock generation from the reference
  // ----------------------------------------------------------------
  // Band 00 uses the short dividers; code 10 is undefined and takes
  // the upper-band data and digital dividers so the clocks never stop
  always_comb begin
    if (band == BAND_300) begin
      data_div = DATACLK_DIV_LOW;
      dig_div  = DIGCLK_DIV_LOW;
    end else begin
      data_div = DATACLK_DIV_HIGH;
      dig_div  = DIGCLK_DIV_HIGH;
    end
    if_div = st_r.ctrl[CTRL_BAND_LO_BIT] ? IF_DIV_HIGH : IF_DIV_LOW;
  end

  tsb_clk_div #(.W(8)) u_dataclk (
    .clk   (pclk),
    .rst_n (presetn),
    .div   (data_div),
    .tick  (dataclk_tick)
  );

  tsb_clk_div #(.W(8)) u_digclk (
    .clk   (pclk),
    .rst_n (presetn),
    .div   (dig_div),
    .tick  (digclk_tick)
  );

  tsb_clk_div #(.W(8)) u_ifref (
    .clk   (pclk),
    .rst_n (presetn),
    .div   (if_div),
    .tick  (ifref_tick)
  );

  // Manchester recovery runs only in receive with the data manager on
  tsb_manchester u_man (
    .clk     (pclk),
    .rst_n   (presetn),
    .enable  (dme && st_r.mode == TSB_RX),
    .din     (sliced_rx_data),
    .bit_out (man_bit),
    .bit_stb (man_stb)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states; unmapped offsets answer with an error
  always_comb begin
    case (paddr)
      TSB_CTRL_OFS, TSB_STATUS_OFS, TSB_CFGA_OFS, TSB_CFGB_OFS,
      TSB_CARR_OFS, TSB_DEV_OFS, TSB_FRX_OFS, TSB_FTXL_OFS,
      TSB_FTXH_OFS, TSB_CMD_OFS: addr_ok = 1'b1;
      default:                   addr_ok = 1'b0;
    endcase
  end

  assign wr_acc  = psel && penable && pwrite && addr_ok;
  assign rd_acc  = psel && penable && !pwrite && addr_ok;
  assign stat_rd = rd_acc && (paddr == TSB_STATUS_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign lvd_set = st_r.ctrl[CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT] && supply_low;

  // Target mode from the request; standby turns into low-voltage mode
  // while the monitor is enabled because the monitor cannot sleep
  always_comb begin
    case (mode_req)
      REQ_RX:  mode_tgt = TSB_RX;
      REQ_TX:  mode_tgt = TSB_TX;
      default: begin
        if (st_r.ctrl[CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT]) begin
          mode_tgt = TSB_LVD;
        end else begin
          mode_tgt = TSB_STANDBY;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Register writes
    if (wr_acc) begin
      case (paddr)
        TSB_CTRL_OFS: st_nxt.ctrl    = pwdata[15:0];
        TSB_CFGA_OFS: st_nxt.cfg_a   = pwdata[15:0];
        TSB_CFGB_OFS: st_nxt.cfg_b   = pwdata[15:0];
        TSB_CARR_OFS: st_nxt.carrier = pwdata[15:0];
        TSB_DEV_OFS:  st_nxt.dev     = pwdata[15:0];
        TSB_FRX_OFS:  st_nxt.f_rx    = pwdata[15:0];
        TSB_FTXL_OFS: st_nxt.f_txl   = pwdata[15:0];
        TSB_FTXH_OFS: st_nxt.f_txh   = pwdata[15:0];
        default: ;
      endcase
    end
    // Configuration swap by command or by wakeup when enabled
    if ((wr_acc && paddr == TSB_CMD_OFS && pwdata[CMD_CFGSW_BIT]) ||
        (wakeup && st_r.ctrl[CTRL_AUTOSW_BIT])) begin
      st_nxt.cfg_sel = ~st_r.cfg_sel;
    end
    st_nxt.rx_cfg = st_nxt.cfg_sel ? st_nxt.cfg_b : st_nxt.cfg_a;

    // Read data is captured in the setup phase and held for access
    if (psel && !penable && !pwrite) begin
      case (paddr)
        TSB_CTRL_OFS:   st_nxt.prdata = {16'h0000, st_r.ctrl};
        TSB_STATUS_OFS: st_nxt.prdata = {24'h000000, st_r.cfg_sel,
                                         st_r.mode, st_r.sw,
                                         st_r.tx_stop, pll_locked,
                                         st_r.lvds};
        TSB_CFGA_OFS:   st_nxt.prdata = {16'h0000, st_r.cfg_a};
        TSB_CFGB_OFS:   st_nxt.prdata = {16'h0000, st_r.cfg_b};
        TSB_CARR_OFS:   st_nxt.prdata = {16'h0000, st_r.carrier};
        TSB_DEV_OFS:    st_nxt.prdata = {16'h0000, st_r.dev};
        TSB_FRX_OFS:    st_nxt.prdata = {16'h0000, st_r.f_rx};
        TSB_FTXL_OFS:   st_nxt.prdata = {16'h0000, st_r.f_txl};
        TSB_FTXH_OFS:   st_nxt.prdata = {16'h0000, st_r.f_txh};
        default:        st_nxt.prdata = 32'h00000000;
      endcase
    end

    // Flag latches; a new low-supply sample beats the read clear
    st_nxt.lvds = (st_r.lvds && !stat_rd) || lvd_set;

    // Mode controller steps only on the digital clock tick
    if (digclk_tick) begin
      st_nxt.mode = mode_tgt;
      if (mode_tgt == TSB_TX && st_r.sw == 1'b0) begin
        st_nxt.sw = 1'b1;
      end else if (mode_tgt == TSB_RX && st_r.sw == 1'b1) begin
        st_nxt.sw = 1'b0;
      end
    end

    // Lock loss in transmit halts the carrier until transmit ends
    if (st_nxt.mode != TSB_TX) begin
      st_nxt.tx_stop = 1'b0;
    end else if (!pll_locked) begin
      st_nxt.tx_stop = 1'b1;
    end
    st_nxt.pa_en = (st_nxt.mode == TSB_TX) && !st_nxt.tx_stop
                   && pll_locked;
    st_nxt.ook   = st_nxt.pa_en && (fsk || tx_coded_data);

    // Synthesizer word: computed or taken from direct registers
    if (st_r.ctrl[CTRL_DIRECT_BIT]) begin
      if (st_r.mode != TSB_TX) begin
        st_nxt.synth = st_r.f_rx;
      end else if (fsk && tx_coded_data) begin
        st_nxt.synth = st_r.f_txh;
      end else begin
        st_nxt.synth = st_r.f_txl;
      end
    end else if (st_r.mode == TSB_TX && fsk && tx_coded_data) begin
      st_nxt.synth = 16'(st_r.carrier + st_r.dev);
    end else begin
      st_nxt.synth = st_r.carrier;
    end

    // Receive path; nothing leaves while the loop is unlocked
    st_nxt.rx_clk = 1'b0;
    if (!pll_locked || st_r.mode != TSB_RX) begin
      st_nxt.rx_data = 1'b0;
    end else if (dme) begin
      st_nxt.rx_clk = man_stb;
      if (man_stb) begin
        st_nxt.rx_data = man_bit;
      end
    end else begin
      st_nxt.rx_data = sliced_rx_data;
    end
  end

  // Everything returns to reset value; mode comes up in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.ctrl    <= CTRL_RST;
      st_r.cfg_a   <= CFG_RST;
      st_r.cfg_b   <= CFG_RST;
      st_r.carrier <= FREQ_RST;
      st_r.dev     <= FREQ_RST;
      st_r.f_rx    <= FREQ_RST;
      st_r.f_txl   <= FREQ_RST;
      st_r.f_txh   <= FREQ_RST;
      st_r.mode    <= TSB_STANDBY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = st_r.prdata;
  assign rf_switch      = st_r.sw;
  assign pa_enable      = st_r.pa_en;
  assign tx_ook_key     = st_r.ook;
  assign synth_word     = st_r.synth;
  assign lna_gain_step  = st_r.ctrl[CTRL_RXGAIN_LSB +: 2];
  assign pa_power_step  = st_r.ctrl[CTRL_TXPWR_LSB +: 2];
  assign rx_data        = st_r.rx_data;
  assign rx_clk         = st_r.rx_clk;
  assign rx_cfg         = st_r.rx_cfg;
  assign lo_mult_four   = (band != BAND_900);
  assign lvd_monitor_on = st_r.ctrl[CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_standby_a: assert property ($rose(presetn) |->
    st_r.mode == TSB_STANDBY && !st_r.lvds) else $error("not standby");
  lvd_set_a: assert property (lvd_set |=> st_r.lvds)
    else $error("low voltage flag not set");
  lvd_hold_a: assert property (st_r.lvds && !stat_rd |=> st_r.lvds)
    else $error("low voltage flag lost");
  lvd_clear_a: assert property (stat_rd && !lvd_set |=>
    !st_r.lvds) else $error("flag not cleared by read");
  lvd_standby_a: assert property (digclk_tick && mode_req == REQ_STANDBY
    && st_r.ctrl[CTRL_LOW_VOLTAGE_DETECT_ENABLE_BIT] |=> st_r.mode == TSB_LVD)
    else $error("standby entered with monitor on");
  rx_gate_a: assert property (!pll_locked |=> !rx_data && !rx_clk)
    else $error("data delivered while unlocked");
  tx_stop_a: assert property (st_r.mode == TSB_TX && !pll_locked
    |=> !pa_enable [*2]) else $error("transmit not stopped");
  switch_dir_a: assert property ((st_r.mode == TSB_TX |-> rf_switch)
    and (st_r.mode == TSB_RX |-> !rf_switch))
    else $error("switch does not match direction");
  raw_rx_a: assert property (!dme && pll_locked && st_r.mode == TSB_RX
    && $stable(st_r.mode) |=> rx_data == $past(sliced_rx_data))
    else $error("raw data not passed");
  div_sel_a: assert property ((band == BAND_300) ==
    (data_div == DATACLK_DIV_LOW) && (dig_div == DIGCLK_DIV_LOW) ==
    (band == BAND_300)) else $error("divider does not follow band");

endmodule

//--- testbench/tsb_host_model.sv
`timescale 1ns/1ps
module tsb_host_model
  import tsb_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic       frc,
  input  wire logic [7:0] pat,
  output logic            coded
);
  logic [4:0] hc;
  logic [3:0] hb;

  // Host sends a repeating byte, MSB first, coded before it leaves;
  // a one goes out high then low, a zero low then high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc    <= 5'h00;
      hb    <= 4'h0;
      coded <= 1'b0;
    end else if (!en) begin
      hc    <= 5'h00;
      hb    <= 4'h0;
      coded <= frc;
    end else begin
      coded <= pat[3'h7 - hb[3:1]] ^ hb[0];
      hc    <= (hc == HALF_BIT_CYCLES[4:0] - 5'h01) ? 5'h00 : hc + 5'h01;
      if (hc == HALF_BIT_CYCLES[4:0] - 5'h01) begin
        hb <= hb + 4'h1;
      end
    end
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import tsb_pkg::*;
  typedef struct packed {
    logic [15:0] c;
    logic        l4;
    logic [7:0]  dg;
    logic [7:0]  dt;
    logic [7:0]  fi;
  } tsb_row_s;
  // Band rows: control word, multiplier, digital/data/IF dividers
  localparam tsb_row_s ROWS [3] = '{
    '{16'h3000, 1'b1, DIGCLK_DIV_LOW, DATACLK_DIV_LOW, IF_DIV_LOW},
    '{16'h2402, 1'b1, DIGCLK_DIV_HIGH, DATACLK_DIV_HIGH, IF_DIV_HIGH},
    '{16'h1806, 1'b0, DIGCLK_DIV_HIGH, DATACLK_DIV_HIGH, IF_DIV_HIGH}};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, supply_low = 0, pll_locked = 1;
  logic        tb_slice = 0, loop = 0, wakeup = 0, hen = 0, hfrc = 0;
  logic        tx_coded_data, rf_switch, pa_enable, tx_ook_key, rx_data;
  logic        rx_clk, dataclk_tick, digclk_tick, ifref_tick;
  logic        lo_mult_four, lvd_monitor_on;
  logic [15:0] synth_word, rx_cfg;
  logic [1:0]  lna_gain_step, pa_power_step;
  logic [7:0]  n;
  int          failures = 0, compares = 0, cnt;
  wire         sliced_rx_data = loop ? tx_coded_data : tb_slice;
  wire  [2:0]  ticks = {ifref_tick, dataclk_tick, digclk_tick};

  always #25 pclk = ~pclk;

  tsb_core i_tsb_core (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_low(supply_low), .pll_locked(pll_locked),
    .sliced_rx_data(sliced_rx_data), .tx_coded_data(tx_coded_data),
    .wakeup(wakeup), .rf_switch(rf_switch), .pa_enable(pa_enable),
    .tx_ook_key(tx_ook_key), .synth_word(synth_word),
    .lna_gain_step(lna_gain_step), .pa_power_step(pa_power_step),
    .rx_data(rx_data), .rx_clk(rx_clk), .rx_cfg(rx_cfg),
    .dataclk_tick(dataclk_tick), .digclk_tick(digclk_tick),
    .ifref_tick(ifref_tick), .lo_mult_four(lo_mult_four),
    .lvd_monitor_on(lvd_monitor_on));

  tsb_host_model i_tsb_host_model (.pclk(pclk), .presetn(presetn),
    .en(hen), .frc(hfrc), .pat(8'ha5), .coded(tx_coded_data));

  // ------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // Cycles between two pulses of the chosen tick
  task per(input int s);
    do cyc(1); while (ticks[s] !== 1'b1);
    n = 8'h00;
    do begin
      cyc(1);
      n++;
    end while (ticks[s] !== 1'b1 && n < 8'd200);
  endtask

  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(TSB_CTRL_OFS, 0, 0);
    chk(q, 0);
    apb(TSB_STATUS_OFS, 0, 0);
    chk(q & 32'hfd, 0);
    chk({rf_switch, lo_mult_four, rx_cfg}, 18'h10000);
  endtask

  task test_done;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog: the whole run needs far fewer cycles than this
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst;
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      apb(TSB_CTRL_OFS, 1, {16'h0, ROWS[i].c});
      apb(TSB_CTRL_OFS, 0, 0);
      chk(q, {16'h0, ROWS[i].c});
      chk(lo_mult_four, ROWS[i].l4);
      chk(lna_gain_step, ROWS[i].c[11:10]);
      chk(pa_power_step, ROWS[i].c[13:12]);
      per(0);
      per(0);
      chk(n, ROWS[i].dg);
      per(1);
      chk(n, ROWS[i].dt);
      per(2);
      chk(n, ROWS[i].fi);
    end
    $display("band table test done");
    apb(8'h3c, 0, 0);
    chk(e, 1);
    chk(q, 0);
    // Frequency words outside transmit: friendly, then direct access
    apb(TSB_CARR_OFS, 1, 32'h1000);
    apb(TSB_DEV_OFS, 1, 32'h0234);
    apb(TSB_FRX_OFS, 1, 32'h0aaa);
    apb(TSB_FTXL_OFS, 1, 32'h00f0);
    apb(TSB_FTXH_OFS, 1, 32'h0f0f);
    cyc(1);
    chk(synth_word, 16'h1000);
    apb(TSB_CTRL_OFS, 1, 32'h0080);
    cyc(2);
    chk(synth_word, 16'h0aaa);
    // Transmit: keying, lock loss and the direction output
    apb(TSB_CTRL_OFS, 1, 32'h0200);
    cyc(90);
    chk({rf_switch, pa_enable}, 2'h3);
    @(posedge pclk) hfrc <= 1'b1;
    cyc(3);
    chk(tx_ook_key, 1);
    @(posedge pclk) hfrc <= 1'b0;
    cyc(3);
    chk(tx_ook_key, 0);
    apb(TSB_CTRL_OFS, 1, 32'h0240);
    cyc(3);
    chk(tx_ook_key, 1);
    // Frequency keying: carrier plus deviation, then the direct words
    @(posedge pclk) hfrc <= 1'b1;
    cyc(3);
    chk(synth_word, 16'h1234);
    apb(TSB_CTRL_OFS, 1, 32'h02c0);
    cyc(2);
    chk(synth_word, 16'h0f0f);
    @(posedge pclk) hfrc <= 1'b0;
    cyc(3);
    chk(synth_word, 16'h00f0);
    @(posedge pclk) pll_locked <= 1'b0;
    cyc(3);
    @(posedge pclk) pll_locked <= 1'b1;
    cyc(3);
    chk(pa_enable, 0);
    apb(TSB_STATUS_OFS, 0, 0);
    chk(q[2], 1);
    apb(TSB_CTRL_OFS, 1, 32'h0100);
    cyc(70);
    chk(rf_switch, 0);
    $display("transmit test done");
    // Receive: raw path, lock gating, decoded path
    @(posedge pclk) tb_slice <= 1'b1;
    cyc(3);
    chk(rx_data, 1);
    @(posedge pclk) tb_slice <= 1'b0;
    cyc(3);
    chk(rx_data, 0);
    @(posedge pclk) pll_locked <= 1'b0;
    @(posedge pclk) tb_slice <= 1'b1;
    cyc(4);
    chk(rx_data, 0);
    @(posedge pclk) pll_locked <= 1'b1;
    apb(TSB_CTRL_OFS, 1, 32'h0120);
    @(posedge pclk) loop <= 1'b1;
    hen <= 1'b1;
    cnt = 0;
    repeat (800) begin
      cyc(1);
      if (rx_clk === 1'b1) cnt++;
    end
    chk(cnt > 4, 1);
    $display("receive test done");
    // Two receiver configurations
    apb(TSB_CFGA_OFS, 1, 32'h1234);
    apb(TSB_CFGB_OFS, 1, 32'h5678);
    cyc(1);
    chk(rx_cfg, 16'h1234);
    apb(TSB_CMD_OFS, 1, 32'h1);
    cyc(2);
    chk(rx_cfg, 16'h5678);
    apb(TSB_CTRL_OFS, 1, 32'h4100);
    @(posedge pclk) wakeup <= 1'b1;
    @(posedge pclk) wakeup <= 1'b0;
    cyc(2);
    chk(rx_cfg, 16'h1234);
    $display("config test done");
    // Supply monitor: latch, read-clear, re-set, standby refusal
    apb(TSB_CTRL_OFS, 1, 32'h0001);
    cyc(1);
    chk(lvd_monitor_on, 1);
    @(posedge pclk) supply_low <= 1'b1;
    @(posedge pclk) supply_low <= 1'b0;
    cyc(90);
    apb(TSB_STATUS_OFS, 0, 0);
    chk({q[6:4], q[0]}, 4'h3);
    apb(TSB_STATUS_OFS, 0, 0);
    chk(q[0], 0);
    @(posedge pclk) supply_low <= 1'b1;
    apb(TSB_STATUS_OFS, 0, 0);
    apb(TSB_STATUS_OFS, 0, 0);
    chk(q[0], 1);
    apb(TSB_CTRL_OFS, 1, 32'h0);
    apb(TSB_STATUS_OFS, 0, 0);
    apb(TSB_STATUS_OFS, 0, 0);
    chk(q[0], 0);
    @(posedge pclk) supply_low <= 1'b0;
    $display("supply monitor test done");
    apb(TSB_CTRL_OFS, 1, 32'h0206);
    rst;
    $display("second reset test done");
    test_done;
  end
endmodule
